// ---- logic/chgreg_bank.sv ----
// Operation
// - optimizer mask bit 6 gates optimizer state change alerts
// - charge-state mask bit 3 gates charging-status change alerts
// - input supply mask bit 0 gates supply status change alerts
// - fault mask bit 7 gates input over-voltage protection alerts
// - fault mask bit 6 gates battery over-current or over-voltage alerts
// - fault mask bit 5 gates system rail over-voltage or short alerts
// - fault mask bit 4 gates boost-mode input rail fault alerts
// - fault mask bit 3 gates die thermal shutdown alerts
// - fault mask bit 0 gates thermistor zone alerts; bits 2:1 read zero
// - optimized limit read-only in 11:4, clamped 05h..A0h, cleared on unplug
// - sixteen-bit registers are little-endian, low byte at lower address
// - converter enable bit 7, default 0, cleared by register reset and watchdog
// - rate bit 6 selects continuous when 0, one-shot pass when 1
// - speed field 5:4 selects 11 to 8 bit resolution, default 11b
// - averaging bit 3 selects single value or running average
// - seed bit 2 starts average from held value or fresh conversion
// - control bit 0 drops aux channel; bit 1 reserved
// - channel disable bits skip input current down to battery voltage channels
// - input current result in 15:1, two's complement, clamped +-5000mA
// - battery current result in 15:3, two's complement, clamped range
// - input and mid-node voltages in 14:2, unsigned, clamped at 20000mV
// - battery voltage in 12:1, unsigned, clamped at 5000mV
// - event flags clear on host read and read zero without new event
// - register-reset control restores defaults and clears itself when done
`timescale 1ns/1ps
`default_nettype none
`include "chgreg_defines.svh"
module chgreg_bank
    import chgreg_pkg::*;
#(
    parameter int CONV_CYCLES = 32
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regResetReq,
    input wire logic watchdogExpire,
    input wire logic adapterUnplug,
    input wire logic [8:0] eventLevels,
    input wire logic [8:0] flagReadStrobe,
    input wire logic optLimitValid,
    input wire logic [7:0] optLimitCode,
    input wire logic [14:0] sampleIbus,
    input wire logic [12:0] sampleIbat,
    input wire logic [12:0] sampleVin,
    input wire logic [12:0] sampleVmid,
    input wire logic [11:0] sampleVbat,
    output logic [7:0] regRdata,
    output logic hostAlert,
    output logic [8:0] eventFlags,
    output logic regResetBusy,
    output logic converterBusy,
    output logic oneShotDone
);
    typedef struct packed {
        logic [7:0] chgMask1;
        logic [7:0] faultMask;
        logic [7:0] adcCtrl;
        logic [7:0] chDis;
        logic [15:0] icoLimit;
        logic [15:0] ibus;
        logic [15:0] ibat;
        logic [15:0] vin;
        logic [15:0] vmid;
        logic [15:0] vbat;
        chgreg_state_t state;
        chgreg_chan_t chan;
        logic [7:0] convCount;
        logic resetBusy;
        logic [7:0] rdata;
        logic alert;
        logic done;
        logic busy;
    } chgreg_state_reg_t;

    chgreg_state_reg_t st_reg;
    chgreg_state_reg_t st_next;
    logic [8:0] maskVec;
    logic [8:0] pulseVec;
    logic [8:0] flagVec;
    logic chanSkip;
    logic [15:0] newWord;
    logic [15:0] oldWord;
    logic [7:0] convLen;

    // per-event mask selection
    always_comb begin
        maskVec = '0;
        maskVec[`CHGREG_EV_OPT] = st_reg.chgMask1[`CHGREG_BIT_OPT_MASK];
        maskVec[`CHGREG_EV_CHGST] = st_reg.chgMask1[`CHGREG_BIT_CHGST_MASK];
        maskVec[`CHGREG_EV_INSUP] = st_reg.chgMask1[`CHGREG_BIT_INSUP_MASK];
        maskVec[`CHGREG_EV_OVP] = st_reg.faultMask[`CHGREG_BIT_OVP_MASK];
        maskVec[`CHGREG_EV_BATF] = st_reg.faultMask[`CHGREG_BIT_BATF_MASK];
        maskVec[`CHGREG_EV_SYSF] = st_reg.faultMask[`CHGREG_BIT_SYSF_MASK];
        maskVec[`CHGREG_EV_BSTF] = st_reg.faultMask[`CHGREG_BIT_BSTF_MASK];
        maskVec[`CHGREG_EV_TSD] = st_reg.faultMask[`CHGREG_BIT_TSD_MASK];
        maskVec[`CHGREG_EV_THZ] = st_reg.faultMask[`CHGREG_BIT_THZ_MASK];
    end

    // one gate per event
    genvar gi;
    generate
        for (gi = 0; gi < `CHGREG_NEVT; gi++) begin : g_evt
            chgreg_alert_gate u_gate (
                .core_clk(core_clk),
                .rst(rst),
                .clkEn(clkEn),
                .softRst(st_reg.resetBusy),
                .eventIn(eventLevels[gi]),
                .maskBit(maskVec[gi]),
                .flagRead(flagReadStrobe[gi]),
                .flag(flagVec[gi]),
                .alertPulse(pulseVec[gi])
            );
        end
    endgenerate

    // channel skip test
    always_comb begin
        unique case (st_reg.chan)
            CHGREG_CH_IBUS: chanSkip = st_reg.chDis[7];
            CHGREG_CH_IBAT: chanSkip = st_reg.chDis[6];
            CHGREG_CH_VIN: chanSkip = st_reg.chDis[5];
            CHGREG_CH_VMID: chanSkip = st_reg.chDis[0];
            CHGREG_CH_VBAT: chanSkip = st_reg.chDis[4];
            default: chanSkip = 1'b1;
        endcase
    end

    // clamped fresh sample
    always_comb begin
        newWord = '0;
        oldWord = '0;
        unique case (st_reg.chan)
            CHGREG_CH_IBUS: begin
                oldWord = st_reg.ibus;
                if (!sampleIbus[14] && sampleIbus > `CHGREG_IBUS_MAX) begin
                    newWord[15:`CHGREG_IBUS_LSB] = `CHGREG_IBUS_MAX;
                end else if (sampleIbus[14] && sampleIbus < `CHGREG_IBUS_MIN) begin
                    newWord[15:`CHGREG_IBUS_LSB] = `CHGREG_IBUS_MIN;
                end else begin
                    newWord[15:`CHGREG_IBUS_LSB] = sampleIbus;
                end
            end
            CHGREG_CH_IBAT: begin
                oldWord = st_reg.ibat;
                if (!sampleIbat[12] && sampleIbat > `CHGREG_IBAT_MAX) begin
                    newWord[15:`CHGREG_IBAT_LSB] = `CHGREG_IBAT_MAX;
                end else if (sampleIbat[12] && sampleIbat < `CHGREG_IBAT_MIN) begin
                    newWord[15:`CHGREG_IBAT_LSB] = `CHGREG_IBAT_MIN;
                end else begin
                    newWord[15:`CHGREG_IBAT_LSB] = sampleIbat;
                end
            end
            CHGREG_CH_VIN: begin
                oldWord = st_reg.vin;
                newWord[14:`CHGREG_VIN_LSB] = (sampleVin > `CHGREG_VIN_MAX) ? `CHGREG_VIN_MAX : sampleVin;
            end
            CHGREG_CH_VMID: begin
                oldWord = st_reg.vmid;
                newWord[14:`CHGREG_VIN_LSB] = (sampleVmid > `CHGREG_VIN_MAX) ? `CHGREG_VIN_MAX : sampleVmid;
            end
            CHGREG_CH_VBAT: begin
                oldWord = st_reg.vbat;
                newWord[12:`CHGREG_VBAT_LSB] = (sampleVbat > `CHGREG_VBAT_MAX) ? `CHGREG_VBAT_MAX : sampleVbat;
            end
            default: begin
                oldWord = '0;
            end
        endcase
    end

    // coarser resolution converts faster: 8 bit is the base length
    assign convLen = 8'(CONV_CYCLES) << (2'b11 - st_reg.adcCtrl[`CHGREG_SPEED_HI:`CHGREG_SPEED_LO]);

    // next state
    always_comb begin
        logic [15:0] avgWord;
        logic [15:0] storeWord;
        logic lastChan;
        avgWord = '0;
        storeWord = '0;
        lastChan = 1'b0;
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.alert = |pulseVec;
        // sign-preserving half sum for the running average
        avgWord = 16'(({oldWord[15], oldWord} + {newWord[15], newWord}) >> `CHGREG_AVG_SHIFT);
        if (!st_reg.adcCtrl[`CHGREG_BIT_AVERAGING_SELECT]) begin
            storeWord = newWord;
        end else if (st_reg.adcCtrl[`CHGREG_BIT_ADC_SEED] && oldWord == `CHGREG_RST_WORD) begin
            storeWord = newWord;
        end else begin
            storeWord = avgWord;
        end
        lastChan = (st_reg.chan == CHGREG_CH_VBAT);
        if (regWrite) begin
            unique case (regAddr)
                `CHGREG_ADDR_CHG_MASK1: st_next.chgMask1 = regWdata & `CHGREG_WMASK_CHG_MASK1;
                `CHGREG_ADDR_FAULT_MASK: st_next.faultMask = regWdata & `CHGREG_WMASK_FAULT_MASK;
                `CHGREG_ADDR_ADC_CTRL: st_next.adcCtrl = regWdata & `CHGREG_WMASK_ADC_CTRL;
                `CHGREG_ADDR_CH_DIS: st_next.chDis = regWdata & `CHGREG_WMASK_CH_DIS;
                default: st_next.chDis = st_next.chDis;
            endcase
        end
        // optimizer limit
        if (adapterUnplug) begin
            st_next.icoLimit = `CHGREG_RST_WORD;
        end else if (optLimitValid) begin
            st_next.icoLimit = '0;
            if (optLimitCode < `CHGREG_ICO_MIN) begin
                st_next.icoLimit[11:`CHGREG_ICO_LSB] = `CHGREG_ICO_MIN;
            end else if (optLimitCode > `CHGREG_ICO_MAX) begin
                st_next.icoLimit[11:`CHGREG_ICO_LSB] = `CHGREG_ICO_MAX;
            end else begin
                st_next.icoLimit[11:`CHGREG_ICO_LSB] = optLimitCode;
            end
        end
        if (watchdogExpire) begin
            st_next.adcCtrl[`CHGREG_BIT_ADC_EN] = 1'b0;
        end
        // converter sequencer; aux channel lives outside this slice
        unique case (st_reg.state)
            CHGREG_IDLE: begin
                st_next.chan = CHGREG_CH_IBUS;
                st_next.convCount = '0;
                if (st_reg.adcCtrl[`CHGREG_BIT_ADC_EN]) begin
                    st_next.state = CHGREG_CONV;
                end
            end
            CHGREG_CONV: begin
                if (!st_reg.adcCtrl[`CHGREG_BIT_ADC_EN]) begin
                    st_next.state = CHGREG_IDLE;
                end else if (chanSkip) begin
                    st_next.state = CHGREG_STORE;
                end else if (st_reg.convCount >= convLen - 8'h01) begin
                    st_next.state = CHGREG_STORE;
                end else begin
                    st_next.convCount = st_reg.convCount + 8'h01;
                end
            end
            CHGREG_STORE: begin
                if (!chanSkip) begin
                    unique case (st_reg.chan)
                        CHGREG_CH_IBUS: st_next.ibus = storeWord;
                        CHGREG_CH_IBAT: st_next.ibat = storeWord;
                        CHGREG_CH_VIN: st_next.vin = storeWord;
                        CHGREG_CH_VMID: st_next.vmid = storeWord;
                        CHGREG_CH_VBAT: st_next.vbat = storeWord;
                        default: st_next.vbat = st_reg.vbat;
                    endcase
                end
                st_next.convCount = '0;
                st_next.state = CHGREG_CONV;
                unique case (st_reg.chan)
                    CHGREG_CH_IBUS: st_next.chan = CHGREG_CH_IBAT;
                    CHGREG_CH_IBAT: st_next.chan = CHGREG_CH_VIN;
                    CHGREG_CH_VIN: st_next.chan = CHGREG_CH_VMID;
                    CHGREG_CH_VMID: st_next.chan = CHGREG_CH_VBAT;
                    default: st_next.chan = CHGREG_CH_IBUS;
                endcase
                if (lastChan && st_reg.adcCtrl[`CHGREG_BIT_ADC_RATE]) begin
                    st_next.adcCtrl[`CHGREG_BIT_ADC_EN] = 1'b0;
                    st_next.state = CHGREG_IDLE;
                    st_next.done = 1'b1;
                end
            end
            default: st_next.state = CHGREG_IDLE;
        endcase
        // little-endian byte readback
        st_next.rdata = '0;
        if (regRead) begin
            unique case (regAddr)
                `CHGREG_ADDR_CHG_MASK1: st_next.rdata = st_reg.chgMask1;
                `CHGREG_ADDR_FAULT_MASK: st_next.rdata = st_reg.faultMask;
                `CHGREG_ADDR_ICO_LO: st_next.rdata = st_reg.icoLimit[7:0];
                `CHGREG_ADDR_ICO_HI: st_next.rdata = st_reg.icoLimit[15:8];
                `CHGREG_ADDR_ADC_CTRL: st_next.rdata = st_reg.adcCtrl;
                `CHGREG_ADDR_CH_DIS: st_next.rdata = st_reg.chDis;
                `CHGREG_ADDR_IBUS_LO: st_next.rdata = st_reg.ibus[7:0];
                `CHGREG_ADDR_IBUS_HI: st_next.rdata = st_reg.ibus[15:8];
                `CHGREG_ADDR_IBAT_LO: st_next.rdata = st_reg.ibat[7:0];
                `CHGREG_ADDR_IBAT_HI: st_next.rdata = st_reg.ibat[15:8];
                `CHGREG_ADDR_VIN_LO: st_next.rdata = st_reg.vin[7:0];
                `CHGREG_ADDR_VIN_HI: st_next.rdata = st_reg.vin[15:8];
                `CHGREG_ADDR_VMID_LO: st_next.rdata = st_reg.vmid[7:0];
                `CHGREG_ADDR_VMID_HI: st_next.rdata = st_reg.vmid[15:8];
                `CHGREG_ADDR_VBAT_LO: st_next.rdata = st_reg.vbat[7:0];
                `CHGREG_ADDR_VBAT_HI: st_next.rdata = st_reg.vbat[15:8];
                default: st_next.rdata = '0;
            endcase
        end
        // register reset: one cycle of defaults
        st_next.resetBusy = regResetReq & ~st_reg.resetBusy;
        if (st_reg.resetBusy) begin
            st_next.chgMask1 = `CHGREG_RST_CHG_MASK1;
            st_next.faultMask = `CHGREG_RST_FAULT_MASK;
            st_next.adcCtrl = `CHGREG_RST_ADC_CTRL;
            st_next.chDis = `CHGREG_RST_CH_DIS;
            st_next.ibus = `CHGREG_RST_WORD;
            st_next.ibat = `CHGREG_RST_WORD;
            st_next.vin = `CHGREG_RST_WORD;
            st_next.vmid = `CHGREG_RST_WORD;
            st_next.vbat = `CHGREG_RST_WORD;
            st_next.state = CHGREG_IDLE;
            st_next.convCount = '0;
            st_next.alert = 1'b0;
            st_next.done = 1'b0;
        end
        st_next.busy = (st_next.state != CHGREG_IDLE);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.adcCtrl <= `CHGREG_RST_ADC_CTRL;
        end else if (clkEn) begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flops
    assign regRdata = st_reg.rdata;
    assign hostAlert = st_reg.alert;
    assign eventFlags = flagVec;
    assign regResetBusy = st_reg.resetBusy;
    assign converterBusy = st_reg.busy;
    assign oneShotDone = st_reg.done;
endmodule
`default_nettype wire

// ---- pkg/chgreg_defines.svh ----
`ifndef CHGREG_DEFINES_SVH
`define CHGREG_DEFINES_SVH

// byte addresses in the register map
`define CHGREG_ADDR_CHG_MASK1 8'h27
`define CHGREG_ADDR_FAULT_MASK 8'h28
`define CHGREG_ADDR_ICO_LO 8'h29
`define CHGREG_ADDR_ICO_HI 8'h2A
`define CHGREG_ADDR_ADC_CTRL 8'h2B
`define CHGREG_ADDR_CH_DIS 8'h2C
`define CHGREG_ADDR_IBUS_LO 8'h2D
`define CHGREG_ADDR_IBUS_HI 8'h2E
`define CHGREG_ADDR_IBAT_LO 8'h2F
`define CHGREG_ADDR_IBAT_HI 8'h30
`define CHGREG_ADDR_VIN_LO 8'h31
`define CHGREG_ADDR_VIN_HI 8'h32
`define CHGREG_ADDR_VMID_LO 8'h33
`define CHGREG_ADDR_VMID_HI 8'h34
`define CHGREG_ADDR_VBAT_LO 8'h35
`define CHGREG_ADDR_VBAT_HI 8'h36

// writable-bit masks; reserved bits read zero
`define CHGREG_WMASK_CHG_MASK1 8'h49
`define CHGREG_WMASK_FAULT_MASK 8'hF9
`define CHGREG_WMASK_ADC_CTRL 8'hFD
`define CHGREG_WMASK_CH_DIS 8'hFF

// reset values
`define CHGREG_RST_CHG_MASK1 8'h00
`define CHGREG_RST_FAULT_MASK 8'h00
`define CHGREG_RST_ADC_CTRL 8'h30
`define CHGREG_RST_CH_DIS 8'h00
`define CHGREG_RST_WORD 16'h0000

// bit positions: second charger mask
`define CHGREG_BIT_OPT_MASK 6
`define CHGREG_BIT_CHGST_MASK 3
`define CHGREG_BIT_INSUP_MASK 0
// bit positions: fault mask
`define CHGREG_BIT_OVP_MASK 7
`define CHGREG_BIT_BATF_MASK 6
`define CHGREG_BIT_SYSF_MASK 5
`define CHGREG_BIT_BSTF_MASK 4
`define CHGREG_BIT_TSD_MASK 3
`define CHGREG_BIT_THZ_MASK 0
// bit positions: converter control
`define CHGREG_BIT_ADC_EN 7
`define CHGREG_BIT_ADC_RATE 6
`define CHGREG_BIT_AVERAGING_SELECT 3
`define CHGREG_BIT_ADC_SEED 2
`define CHGREG_BIT_AUX_OFF 0
`define CHGREG_SPEED_HI 5
`define CHGREG_SPEED_LO 4

// event indices
`define CHGREG_NEVT 9
`define CHGREG_EV_OPT 0
`define CHGREG_EV_CHGST 1
`define CHGREG_EV_INSUP 2
`define CHGREG_EV_OVP 3
`define CHGREG_EV_BATF 4
`define CHGREG_EV_SYSF 5
`define CHGREG_EV_BSTF 6
`define CHGREG_EV_TSD 7
`define CHGREG_EV_THZ 8

// result field layouts
`define CHGREG_ICO_LSB 4
`define CHGREG_ICO_W 8
`define CHGREG_ICO_MIN 8'h05
`define CHGREG_ICO_MAX 8'hA0
`define CHGREG_IBUS_LSB 1
`define CHGREG_IBUS_W 15
`define CHGREG_IBUS_MAX 15'h07D0
`define CHGREG_IBUS_MIN 15'h7830
`define CHGREG_IBAT_LSB 3
`define CHGREG_IBAT_W 13
`define CHGREG_IBAT_MAX 13'h03ED
`define CHGREG_IBAT_MIN 13'h1830
`define CHGREG_VIN_LSB 2
`define CHGREG_VIN_W 13
`define CHGREG_VIN_MAX 13'h0FA0
`define CHGREG_VBAT_LSB 1
`define CHGREG_VBAT_W 12
`define CHGREG_VBAT_MAX 12'hFA0

// conversion pass length and average shift
`define CHGREG_CONV_CYCLES 8'h20
`define CHGREG_AVG_SHIFT 1

`endif

// ---- pkg/chgreg_pkg.sv ----
package chgreg_pkg;
    typedef enum logic [1:0] {
        CHGREG_IDLE = 2'b00,
        CHGREG_CONV = 2'b01,
        CHGREG_STORE = 2'b10
    } chgreg_state_t;
    typedef enum logic [2:0] {
        CHGREG_CH_IBUS = 3'b000,
        CHGREG_CH_IBAT = 3'b001,
        CHGREG_CH_VIN = 3'b010,
        CHGREG_CH_VMID = 3'b011,
        CHGREG_CH_VBAT = 3'b100
    } chgreg_chan_t;
endpackage

// ---- logic/chgreg_alert_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "chgreg_defines.svh"
// one event: edge detect, flag, mask
module chgreg_alert_gate
    import chgreg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic softRst,
    input wire logic eventIn,
    input wire logic maskBit,
    input wire logic flagRead,
    output logic flag,
    output logic alertPulse
);
    typedef struct packed {
        logic eventPrev;
        logic flag;
    } chgreg_gate_t;
    chgreg_gate_t gate_reg;
    chgreg_gate_t gate_next;
    logic rise;

    // set beats read-clear so a simultaneous event is not lost
    always_comb begin
        gate_next = gate_reg;
        rise = eventIn & ~gate_reg.eventPrev;
        gate_next.eventPrev = eventIn;
        if (softRst) begin
            gate_next.flag = 1'b0;
        end else if (rise) begin
            gate_next.flag = 1'b1;
        end else if (flagRead) begin
            gate_next.flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gate_reg <= '0;
            alertPulse <= 1'b0;
        end else if (clkEn) begin
            gate_reg <= gate_next;
            alertPulse <= rise & ~maskBit & ~softRst;
        end
    end

    assign flag = gate_reg.flag;
endmodule
`default_nettype wire

// ---- verification/chgreg_bank_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module chgreg_bank_checker
    import chgreg_pkg::*;
#(
    parameter int CONV_CYCLES = 32
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regResetReq,
    input wire logic [8:0] eventLevels,
    input wire logic [8:0] flagReadStrobe,
    input wire logic [7:0] regRdata,
    input wire logic hostAlert,
    input wire logic [8:0] eventFlags,
    input wire logic regResetBusy
);
    logic [7:0] faultMask_reg;
    // shadow of the fault mask
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) faultMask_reg <= 8'h00;
        else if (clkEn && regResetReq) faultMask_reg <= 8'h00;
        else if (clkEn && regWrite && regAddr == 8'h28) faultMask_reg <= regWdata;
    end
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    sequence s_rd(logic [7:0] a);
        clkEn && regRead && regAddr == a;
    endsequence
    sequence s_busyOnce;
        regResetBusy ##1 !regResetBusy;
    endsequence
    property p_faultRsvd;
        s_rd(8'h28) |=> regRdata[2:1] == 2'h0;
    endproperty
    a_faultRsvd: assert property (p_faultRsvd) else $error("fault rsvd bits");
    property p_ctrlRsvd;
        s_rd(8'h2B) |=> !regRdata[1];
    endproperty
    a_ctrlRsvd: assert property (p_ctrlRsvd) else $error("ctrl rsvd bit");
    property p_vbatRsvd;
        s_rd(8'h36) |=> regRdata[7:5] == 3'h0;
    endproperty
    a_vbatRsvd: assert property (p_vbatRsvd) else $error("vbat high bits");
    property p_icoRsvd;
        s_rd(8'h2A) |=> regRdata[7:4] == 4'h0;
    endproperty
    a_icoRsvd: assert property (p_icoRsvd) else $error("limit high nibble set");
    property p_ovpPass;
        clkEn && $rose(eventLevels[3]) && !faultMask_reg[7] |=> ##1 hostAlert;
    endproperty
    a_ovpPass: assert property (p_ovpPass) else $error("no alert");
    property p_tsdBlock;
        clkEn && $rose(eventLevels[7]) && faultMask_reg[3] |=> ##1 !hostAlert;
    endproperty
    a_tsdBlock: assert property (p_tsdBlock) else $error("masked alert");
    property p_alertCause;
        hostAlert |-> eventFlags != 9'h000;
    endproperty
    a_alertCause: assert property (p_alertCause) else $error("alert without flag");
    property p_flagHold;
        !$past(regResetReq) && !$past(regResetBusy)
            |-> (($past(eventFlags) & ~$past(flagReadStrobe)) & ~eventFlags) == 9'h000;
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag dropped");
    property p_resetBusy;
        clkEn && regResetReq |=> s_busyOnce;
    endproperty
    a_resetBusy: assert property (p_resetBusy) else $error("busy length");
endmodule
`default_nettype wire

// ---- verification/chgreg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module chgreg_host_model
    import chgreg_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] regRdata,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regAddr,
    output logic [7:0] regWdata
);
    // idle bus at time zero
    initial {regWrite, regRead, regAddr, regWdata} = '0;
    // one byte access, one taking edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge core_clk);
        {regWrite, regRead} = {wr, !wr};
        {regAddr, regWdata} = {a, d};
        @(negedge core_clk);
        q = regRdata;
        {regWrite, regRead} = 2'b00;
        {regAddr, regWdata} = ~{a, d}; // no stale value
    endtask
endmodule
`default_nettype wire

// ---- verification/chgreg_bank_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module chgreg_bank_tb
    import chgreg_pkg::*;
;
    localparam int CONV = 2;
    localparam int EV_BIT [9] = '{6, 3, 0, 7, 6, 5, 4, 3, 0};
    logic core_clk, rst, clkEn, regWrite, regRead, regResetReq, watchdogExpire, adapterUnplug, optLimitValid;
    logic hostAlert, regResetBusy, converterBusy, oneShotDone;
    logic [7:0] regAddr, regWdata, regRdata, optLimitCode, q;
    logic [8:0] eventLevels, flagReadStrobe, eventFlags;
    logic [14:0] sampleIbus;
    logic [12:0] sampleIbat, sampleVin, sampleVmid;
    logic [11:0] sampleVbat;
    logic [15:0] w;
    int errorCnt, checks, n;
    chgreg_bank #(.CONV_CYCLES(CONV)) dut_u (.core_clk, .rst, .clkEn, .regWrite, .regRead, .regAddr,
        .regWdata, .regResetReq, .watchdogExpire, .adapterUnplug, .eventLevels, .flagReadStrobe,
        .optLimitValid, .optLimitCode, .sampleIbus, .sampleIbat, .sampleVin, .sampleVmid, .sampleVbat,
        .regRdata, .hostAlert, .eventFlags, .regResetBusy, .converterBusy, .oneShotDone);
    chgreg_host_model host_u (.core_clk, .regRdata, .regWrite, .regRead, .regAddr, .regWdata);
    // free running clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (errorCnt == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.xfer(1'b1, a, d, q);
    endtask
    // low byte at base, high byte at base plus one
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        logic [7:0] lo;
        host_u.xfer(1'b0, a, 8'h00, lo);
        host_u.xfer(1'b0, a + 8'h01, 8'h00, q);
        v = {q, lo};
    endtask
    task automatic pulse(ref logic s);
        @(negedge core_clk) s = 1'b1;
        @(negedge core_clk) s = 1'b0;
    endtask
    // reset values, unmapped too
    task automatic defaults();
        for (int a = 'h26; a <= 'h37; a++) begin
            host_u.xfer(1'b0, 8'(a), 8'h00, q);
            chk(16'(q), (a == 'h2B) ? 16'h0030 : 16'h0000);
        end
    endtask
    // raise one event, count alert cycles
    task automatic fire(input int i, output int cnt);
        cnt = 0;
        @(negedge core_clk) eventLevels[i] = 1'b1;
        repeat (4) begin
            @(negedge core_clk);
            cnt += int'(hostAlert === 1'b1);
        end
        eventLevels[i] = 1'b0;
    endtask
    task automatic strobe(input int i);
        @(negedge core_clk) flagReadStrobe[i] = 1'b1;
        @(negedge core_clk) flagReadStrobe = 9'h000;
    endtask
    task automatic waitDone();
        n = 0;
        while (oneShotDone !== 1'b1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        chk(16'(oneShotDone), 16'h0001);
    endtask
    // hang guard
    initial begin
        #2000000;
        errorCnt++;
        summarize();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        {regResetReq, watchdogExpire, adapterUnplug, optLimitValid} = 4'h0;
        {eventLevels, flagReadStrobe, optLimitCode} = '0;
        {sampleIbus, sampleIbat, sampleVin, sampleVmid, sampleVbat} = '0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk) rst = 1'b0;
        defaults();
        for (int a = 'h26; a <= 'h37; a++) wr(8'(a), 8'h7F);
        for (int a = 'h26; a <= 'h37; a++) begin
            host_u.xfer(1'b0, 8'(a), 8'h00, q);
            chk(16'(q), a == 'h27 ? 16'h0049 : a == 'h28 ? 16'h0079 : a == 'h2B ? 16'h007D :
                a == 'h2C ? 16'h007F : 16'h0000);
        end
        @(negedge core_clk) regResetReq = 1'b1;
        @(negedge core_clk) regResetReq = 1'b0;
        chk(16'(regResetBusy), 16'h0001);
        @(negedge core_clk);
        chk(16'(regResetBusy), 16'h0000);
        defaults();
        for (int i = 0; i < 9; i++) begin
            wr((i < 3) ? 8'h27 : 8'h28, 8'h01 << EV_BIT[i]);
            fire(i, n);
            chk(16'(n), 16'h0000);
            strobe(i);
            wr((i < 3) ? 8'h27 : 8'h28, 8'h00);
            fire(i, n);
            chk(16'(n), 16'h0001);
            chk(16'(eventFlags[i]), 16'h0001);
            strobe(i);
            chk(16'(eventFlags[i]), 16'h0000);
        end
        foreach (EV_BIT[k]) if (k < 3) begin
            optLimitCode = (k == 0) ? 8'h50 : (k == 1) ? 8'h02 : 8'hFF;
            pulse(optLimitValid);
            rd16(8'h29, w);
            chk(w, (k == 0) ? 16'h0500 : (k == 1) ? 16'h0050 : 16'h0A00);
        end
        wr(8'h29, 8'h55);
        wr(8'h2A, 8'h55);
        rd16(8'h29, w);
        chk(w, 16'h0A00);
        pulse(adapterUnplug);
        rd16(8'h29, w);
        chk(w, 16'h0000);
        // clamped and in-range samples, one-shot pass at finest speed
        {sampleIbus, sampleIbat, sampleVin} = {15'h7000, 13'h0100, 13'h1FFF};
        {sampleVmid, sampleVbat} = {13'h0123, 12'hFFF};
        wr(8'h2B, 8'hC0);
        @(negedge core_clk);
        chk(16'(converterBusy), 16'h0001);
        waitDone();
        foreach (EV_BIT[k]) if (k < 5) begin
            rd16(8'h2D + 8'(2 * k), w);
            chk(w, k == 0 ? 16'hF060 : k == 1 ? 16'h0800 : k == 2 ? 16'h3E80 :
                k == 3 ? 16'h048C : 16'h1F40);
        end
        host_u.xfer(1'b0, 8'h2B, 8'h00, q);
        chk(16'(q), 16'h0040);
        // battery current skipped, mid-node averaged from held value
        {sampleIbat, sampleVmid} = {13'h0200, 13'h00A3};
        wr(8'h2C, 8'h40);
        wr(8'h2B, 8'hC8);
        waitDone();
        rd16(8'h2F, w);
        chk(w, 16'h0800);
        rd16(8'h33, w);
        chk(w, 16'h038C);
        wr(8'h2B, 8'h80);
        pulse(watchdogExpire);
        host_u.xfer(1'b0, 8'h2B, 8'h00, q);
        chk(16'(q), 16'h0000);
        summarize();
    end
endmodule
bind chgreg_bank chgreg_bank_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_u (.core_clk, .rst, .clkEn,
    .regWrite, .regRead, .regAddr, .regWdata, .regResetReq, .eventLevels, .flagReadStrobe,
    .regRdata, .hostAlert, .eventFlags, .regResetBusy);
`default_nettype wire
